//--- core/adc_mode_ctrl.sv
// Mode selection, calibration trigger and reference clock gating of the converter
`timescale 1ns/1ns

//Contract
// R1: Enabled reference outputs A and B both toggle at sampling clock over four.
// R2: Reference outputs gated by register Eh bit 1, disabled after reset.
// R3: Pin mode, dual-edge pin high selects interleaved mode, Q input ignored.
// R4: Pin mode, dual-edge pin low gives independent I and Q channels.
// R5: Extended control takes dual-edge mode from register 0h bit 7, default off.
// R6: Power-save pin high selects low-rate power-save mode, low selects normal.
// R7: Power-save output is SDR when demuxed 1:2, DDR when 1:1.
// R8: Host keeps sample rate at most 800 MSPS in power-save independent mode.
// R9: Low for minimum time then high for minimum time runs one calibration.
// R10: Calibration pin always active, ORed with register 0h bit 15 in extended control.
// R11: Calibration-running output high exactly while calibration runs.
// R12: Power-down pin high powers channel down, low returns it to operation.
// R13: Power-down pins always active, ORed with 0h bits 11 and 10 in extended control.
// R14: Pin mode, test-pattern pin high outputs a fixed repeating pattern.
// R15: Extended control enables test pattern only from register 0h bit 12.
// R16: Demux pin high selects 1:1 output, low selects 1:2.
// R17: Demux ratio follows its pin in every mode, no register override.
// R18: Pin mode, range pin sets one common range, low lower, high higher.
// R19: Extended control takes I range from register 3h, Q range from Bh.
// R20: Pin high range equals middle register code, pin low the minimum code.
// R21: Extended control while enable_n low; high resets registers, port disabled.
// R22: Dual-edge mode samples both clock edges, otherwise rising edges only.
// R23: One calibration start pulse per qualified rising edge of combined request.
// R24: All control pins synchronised before use in mode logic.
module adc_mode_ctrl #(
    parameter int CAL_LOW_CYC  = adc_ctrl_pkg::CAL_LOW_CYC,
    parameter int CAL_HIGH_CYC = adc_ctrl_pkg::CAL_HIGH_CYC,
    parameter int CAL_RUN_CYC  = adc_ctrl_pkg::CAL_RUN_CYC
) (
    input  wire logic        MCLK,                      // Sampling clock
    input  wire logic        RSTN,                      // Async reset, active low
    input  wire logic        EXTENDED_CONTROL_ENABLE_N, // Pin, low = register control
    input  wire logic        DUAL_EDGE_SEL,             // Pin, dual-edge select
    input  wire logic        LOW_RATE_POWER_SAVE,       // Pin, power-save select
    input  wire logic        CALIB_REQ,                 // Pin, calibration request
    input  wire logic        POWER_DOWN_I,              // Pin, I channel down
    input  wire logic        POWER_DOWN_Q,              // Pin, Q channel down
    input  wire logic        TEST_PATTERN_SELECT,       // Pin, test pattern
    input  wire logic        DEMUX_RATIO_SELECT,        // Pin, high = 1:1
    input  wire logic        RANGE_SELECT,              // Pin, full-scale range
    input  wire logic [3:0]  ADDR,                      // Register index
    input  wire logic [15:0] WDATA,                     // Write data
    input  wire logic        WR,                        // Write strobe
    input  wire logic        RD,                        // Read strobe
    output logic      [15:0] RDATA,                     // Read data, cycle after RD
    output logic             REF_CLK_OUT_A,             // Reference clock A
    output logic             REF_CLK_OUT_B,             // Reference clock B
    output logic             DUAL_EDGE_MODE,            // Both edges sample I input
    output logic             LOW_POWER_MODE,            // Low-rate power save
    output logic             OUT_DDR,                   // Output double data rate
    output logic             DEMUX_1TO1,                // Output bus 1:1
    output logic             CH_I_OFF,                  // I channel powered down
    output logic             CH_Q_OFF,                  // Q channel powered down
    output logic             TEST_PATTERN_ON,           // Test pattern on outputs
    output logic      [7:0]  RANGE_I,                   // I full-scale range code
    output logic      [7:0]  RANGE_Q,                   // Q full-scale range code
    output logic             CALIB_RUNNING              // Calibration in progress
);

    localparam int CNT_W = 16;

    if (CAL_LOW_CYC < 1 || CAL_HIGH_CYC < 1 || CAL_RUN_CYC < 9 ||
        CAL_RUN_CYC >= 2**CNT_W || CAL_LOW_CYC >= 2**CNT_W ||
        CAL_HIGH_CYC >= 2**CNT_W) begin : g_bad_param
        $error("adc_mode_ctrl: calibration counts out of range");
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Pins are asynchronous; a change only counts once stages 2 and 3 agree
    localparam int NPIN = $bits(adc_ctrl_pkg::pins_type);

    adc_ctrl_pkg::pins_type pins_raw;
    adc_ctrl_pkg::pins_type pins_reg;
    logic [NPIN-1:0]        s1_reg;
    logic [NPIN-1:0]        s2_reg;
    logic [NPIN-1:0]        s3_reg;

    assign pins_raw = '{ext_n: EXTENDED_CONTROL_ENABLE_N, dual_edge: DUAL_EDGE_SEL,
                        low_power: LOW_RATE_POWER_SAVE, cal: CALIB_REQ,
                        pd_i: POWER_DOWN_I, pd_q: POWER_DOWN_Q,
                        test_pat: TEST_PATTERN_SELECT, demux: DEMUX_RATIO_SELECT,
                        range: RANGE_SELECT};

    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge MCLK or negedge RSTN) begin
            if (!RSTN) begin
                s1_reg[i]   <= adc_ctrl_pkg::PINS_RESET[i];
                s2_reg[i]   <= adc_ctrl_pkg::PINS_RESET[i];
                s3_reg[i]   <= adc_ctrl_pkg::PINS_RESET[i];
                pins_reg[i] <= adc_ctrl_pkg::PINS_RESET[i];
            end else begin
                s1_reg[i] <= pins_raw[i];               // R24
                s2_reg[i] <= s1_reg[i];
                s3_reg[i] <= s2_reg[i];
                if (s2_reg[i] == s3_reg[i]) begin
                    pins_reg[i] <= s3_reg[i];           // R24
                end
            end
        end
    end

    wire ext = ~pins_reg.ext_n;                          // R21

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic [15:0] ctrl_reg;
    logic [15:0] refclk_reg;
    logic [15:0] range_i_reg;
    logic [15:0] range_q_reg;

    wire wr_ok = WR & ext;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_reg    <= adc_ctrl_pkg::CTRL_RESET;
            refclk_reg  <= adc_ctrl_pkg::REFCLK_RESET;
            range_i_reg <= adc_ctrl_pkg::RANGE_RESET;
            range_q_reg <= adc_ctrl_pkg::RANGE_RESET;
        end else if (!ext) begin
            ctrl_reg    <= adc_ctrl_pkg::CTRL_RESET;    // R21
            refclk_reg  <= adc_ctrl_pkg::REFCLK_RESET;  // R21
            range_i_reg <= adc_ctrl_pkg::RANGE_RESET;
            range_q_reg <= adc_ctrl_pkg::RANGE_RESET;
        end else if (wr_ok) begin
            if (ADDR == adc_ctrl_pkg::ADDR_CTRL)    ctrl_reg    <= WDATA;
            if (ADDR == adc_ctrl_pkg::ADDR_REFCLK)  refclk_reg  <= WDATA;
            if (ADDR == adc_ctrl_pkg::ADDR_RANGE_I) range_i_reg <= WDATA;
            if (ADDR == adc_ctrl_pkg::ADDR_RANGE_Q) range_q_reg <= WDATA;
        end
    end

    // ----------------------------------------
    // Mode resolution
    // ----------------------------------------
    wire reg_des = ctrl_reg[adc_ctrl_pkg::CTRL_DES_BIT];
    wire reg_tp  = ctrl_reg[adc_ctrl_pkg::CTRL_TP_BIT];
    wire reg_pdi = ctrl_reg[adc_ctrl_pkg::CTRL_PDI_BIT];
    wire reg_pdq = ctrl_reg[adc_ctrl_pkg::CTRL_PDQ_BIT];
    wire reg_cal = ctrl_reg[adc_ctrl_pkg::CTRL_CAL_BIT];
    wire ref_en  = refclk_reg[adc_ctrl_pkg::REF_EN_BIT];

    wire       des_next  = ext ? reg_des : pins_reg.dual_edge;          // R3 R4 R5 R22
    wire       pdi_next  = pins_reg.pd_i | (ext & reg_pdi);             // R12 R13
    wire       pdq_next  = pins_reg.pd_q | (ext & reg_pdq);             // R12 R13
    wire       tp_next   = ext ? reg_tp : pins_reg.test_pat;            // R14 R15
    // Outside power save the output stays DDR regardless of ratio
    wire       ddr_next  = pins_reg.low_power ? pins_reg.demux : 1'b1;  // R7
    wire [7:0] pin_range = pins_reg.range ? adc_ctrl_pkg::RANGE_MID
                                          : adc_ctrl_pkg::RANGE_MIN;    // R18 R20
    wire [7:0] ri_next   = ext ? range_i_reg[7:0] : pin_range;          // R19
    wire [7:0] rq_next   = ext ? range_q_reg[7:0] : pin_range;          // R19

    // ----------------------------------------
    // Reference clock divider
    // ----------------------------------------
    logic [1:0] div_reg;
    logic       ref_reg;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            div_reg <= 2'h0;
            ref_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            ref_reg <= ref_en & div_reg[1];             // R1 R2
        end
    end

    // ----------------------------------------
    // Calibration trigger
    // ----------------------------------------
    // Requiring a qualified low first stops a stuck-high request re-firing
    adc_ctrl_pkg::cal_state_type cal_state_reg;
    adc_ctrl_pkg::cal_state_type cal_state_next;
    logic [CNT_W-1:0]            cnt_reg;
    logic [CNT_W-1:0]            cnt_next;

    wire cal_req   = pins_reg.cal | (ext & reg_cal);    // R10
    wire low_done  = cnt_reg == CNT_W'(CAL_LOW_CYC - 1);
    // At least the minimum; a one-cycle minimum still needs two high cycles
    wire high_done = cnt_reg >= CNT_W'(CAL_HIGH_CYC - 1);
    wire run_done  = cnt_reg == CNT_W'(CAL_RUN_CYC - 1);
    wire cal_start = (cal_state_reg == adc_ctrl_pkg::CAL_HIGH) & cal_req & high_done;

    always_comb begin
        cal_state_next = cal_state_reg;
        cnt_next       = cnt_reg + CNT_W'(1);
        case (cal_state_reg)
            adc_ctrl_pkg::CAL_WAIT_LOW: begin
                if (cal_req) begin
                    cnt_next = '0;
                end else if (low_done) begin
                    cal_state_next = adc_ctrl_pkg::CAL_ARMED;   // R9
                end
            end
            adc_ctrl_pkg::CAL_ARMED: begin
                cnt_next = '0;
                if (cal_req) begin
                    cal_state_next = adc_ctrl_pkg::CAL_HIGH;
                    cnt_next       = CNT_W'(1);
                end
            end
            adc_ctrl_pkg::CAL_HIGH: begin
                if (!cal_req) begin
                    cal_state_next = adc_ctrl_pkg::CAL_WAIT_LOW;
                    cnt_next       = '0;
                end else if (high_done) begin
                    cal_state_next = adc_ctrl_pkg::CAL_RUN;     // R9 R23
                    cnt_next       = '0;
                end
            end
            adc_ctrl_pkg::CAL_RUN: begin
                if (run_done) begin
                    cal_state_next = adc_ctrl_pkg::CAL_WAIT_LOW;
                    cnt_next       = '0;
                end
            end
            default: begin
                cal_state_next = adc_ctrl_pkg::CAL_WAIT_LOW;
                cnt_next       = '0;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            cal_state_reg <= adc_ctrl_pkg::CAL_WAIT_LOW;
            cnt_reg       <= '0;
        end else begin
            cal_state_reg <= cal_state_next;
            cnt_reg       <= cnt_next;
        end
    end

    // ----------------------------------------
    // Read path and output flops
    // ----------------------------------------
    wire [15:0] status = {9'h000, CALIB_RUNNING, TEST_PATTERN_ON, CH_Q_OFF, CH_I_OFF,
                          DEMUX_1TO1, LOW_POWER_MODE, DUAL_EDGE_MODE};

    // Port is dead outside extended control, unmapped indices read zero
    wire [15:0] rd_mux = !ext                                  ? 16'h0000 :
                         (ADDR == adc_ctrl_pkg::ADDR_CTRL)    ? ctrl_reg :
                         (ADDR == adc_ctrl_pkg::ADDR_STATUS)  ? status :
                         (ADDR == adc_ctrl_pkg::ADDR_RANGE_I) ? range_i_reg :
                         (ADDR == adc_ctrl_pkg::ADDR_RANGE_Q) ? range_q_reg :
                         (ADDR == adc_ctrl_pkg::ADDR_REFCLK)  ? refclk_reg : 16'h0000;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA           <= 16'h0000;
            REF_CLK_OUT_A   <= 1'b0;
            REF_CLK_OUT_B   <= 1'b0;
            DUAL_EDGE_MODE  <= 1'b0;
            LOW_POWER_MODE  <= 1'b0;
            OUT_DDR         <= 1'b1;
            DEMUX_1TO1      <= 1'b0;
            CH_I_OFF        <= 1'b0;
            CH_Q_OFF        <= 1'b0;
            TEST_PATTERN_ON <= 1'b0;
            RANGE_I         <= adc_ctrl_pkg::RANGE_MIN;
            RANGE_Q         <= adc_ctrl_pkg::RANGE_MIN;
            CALIB_RUNNING   <= 1'b0;
        end else begin
            RDATA           <= RD ? rd_mux : 16'h0000;
            REF_CLK_OUT_A   <= ref_reg;                 // R1
            REF_CLK_OUT_B   <= ref_reg;                 // R1
            DUAL_EDGE_MODE  <= des_next;                // R22
            LOW_POWER_MODE  <= pins_reg.low_power;      // R6
            OUT_DDR         <= ddr_next;
            DEMUX_1TO1      <= pins_reg.demux;          // R16 R17
            CH_I_OFF        <= pdi_next;
            CH_Q_OFF        <= pdq_next;
            TEST_PATTERN_ON <= tp_next;
            RANGE_I         <= ri_next;
            RANGE_Q         <= rq_next;
            CALIB_RUNNING   <= cal_state_next == adc_ctrl_pkg::CAL_RUN;  // R11
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    ref_toggle_a: assert property ( // R1
        $past(ref_en) && $past(ref_en, 3) |=> REF_CLK_OUT_A != $past(REF_CLK_OUT_A, 2)
            && REF_CLK_OUT_B == REF_CLK_OUT_A)
        else $error("reference clock not at quarter rate");

    ref_gate_a: assert property ( // R2
        !ref_en ##1 1 |=> !REF_CLK_OUT_A && !REF_CLK_OUT_B)
        else $error("reference clock runs while disabled");

    des_pin_a: assert property ( // R3
        !ext |=> DUAL_EDGE_MODE == $past(pins_reg.dual_edge))
        else $error("dual-edge mode does not follow pin");

    des_reg_a: assert property ( // R5
        ext |=> DUAL_EDGE_MODE == $past(reg_des))
        else $error("dual-edge mode does not follow register");

    ddr_sel_a: assert property ( // R7
        pins_reg.low_power |=> OUT_DDR == $past(pins_reg.demux) && LOW_POWER_MODE)
        else $error("power-save output rate wrong");

    pd_or_a: assert property ( // R13
        1'b1 |=> CH_I_OFF == $past(pins_reg.pd_i | (ext & reg_pdi))
            && CH_Q_OFF == $past(pins_reg.pd_q | (ext & reg_pdq)))
        else $error("power-down resolution wrong");

    tp_sel_a: assert property ( // R15
        ext && !reg_tp |=> !TEST_PATTERN_ON)
        else $error("test pattern on without register bit");

    demux_pin_a: assert property ( // R17
        1'b1 |=> DEMUX_1TO1 == $past(pins_reg.demux))
        else $error("demux ratio not from pin");

    range_pin_a: assert property ( // R20
        !ext && pins_reg.range |=> RANGE_I == adc_ctrl_pkg::RANGE_MID
            && RANGE_Q == adc_ctrl_pkg::RANGE_MID)
        else $error("pin high range not mid code");

    regs_dflt_a: assert property ( // R21
        !ext |=> ctrl_reg == adc_ctrl_pkg::CTRL_RESET
            && refclk_reg == adc_ctrl_pkg::REFCLK_RESET)
        else $error("registers not at defaults outside extended control");

    cal_run_a: assert property ( // R11
        cal_start |=> CALIB_RUNNING [*8])
        else $error("calibration running flag dropped early");

    cal_once_a: assert property ( // R23
        cal_start |=> !cal_start [*8])
        else $error("second calibration start too soon");

    cal_cause_a: assert property ( // R9
        $rose(CALIB_RUNNING) |-> $past(cal_req, 1) && $past(cal_req, CAL_HIGH_CYC))
        else $error("calibration started without held request");

    lp_pin_a: assert property ( // R6
        1'b1 |=> LOW_POWER_MODE == $past(pins_reg.low_power))
        else $error("power-save mode does not follow pin");

    tp_pin_a: assert property ( // R14
        !ext |=> TEST_PATTERN_ON == $past(pins_reg.test_pat))
        else $error("test pattern does not follow pin");

    range_low_a: assert property ( // R18
        !ext && !pins_reg.range |=> RANGE_I == adc_ctrl_pkg::RANGE_MIN
            && RANGE_Q == adc_ctrl_pkg::RANGE_MIN)
        else $error("pin low range not min code");

    range_reg_a: assert property ( // R19
        ext |=> RANGE_I == $past(range_i_reg[7:0]) && RANGE_Q == $past(range_q_reg[7:0]))
        else $error("range codes not from registers");

    // A resolved pin may only move on an edge where stages 2 and 3 agreed
    sync_agree_a: assert property ( // R24
        ((pins_reg ^ $past(pins_reg)) & $past(s2_reg ^ s3_reg)) == '0)
        else $error("pin change passed without synchroniser agreement");

    cal_seen_c:  cover property (cal_start ##1 CALIB_RUNNING);
    ref_run_c:   cover property ($rose(REF_CLK_OUT_A) ##2 $fell(REF_CLK_OUT_A));
    ext_des_c:   cover property (ext && reg_des ##1 DUAL_EDGE_MODE);
    cal_abort_c: cover property (cal_state_reg == adc_ctrl_pkg::CAL_HIGH && !cal_req);
    tp_pin_c:    cover property (!ext && pins_reg.test_pat ##1 TEST_PATTERN_ON);

endmodule

//--- shared/adc_ctrl_pkg.sv
// Constants, register map and carrier types for the converter mode-control block
package adc_ctrl_pkg;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 16;
    localparam logic [3:0]  ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_STATUS  = 4'h1;
    localparam logic [3:0]  ADDR_RANGE_I = 4'h3;
    localparam logic [3:0]  ADDR_RANGE_Q = 4'hb;
    localparam logic [3:0]  ADDR_REFCLK  = 4'he;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_CAL_BIT  = 15;
    localparam int CTRL_TP_BIT   = 12;
    localparam int CTRL_PDI_BIT  = 11;
    localparam int CTRL_PDQ_BIT  = 10;
    localparam int CTRL_DES_BIT  = 7;
    localparam int REF_EN_BIT    = 1;

    // ----------------------------------------
    // Reset values and range codes
    // ----------------------------------------
    localparam int          RANGE_W      = 8;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] REFCLK_RESET = 16'h0000;
    localparam logic [7:0]  RANGE_MIN    = 8'h00;
    localparam logic [7:0]  RANGE_MID    = 8'h80;
    localparam logic [15:0] RANGE_RESET  = 16'h0080;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS      = 100;
    localparam int CAL_LOW_NS  = 400;
    localparam int CAL_HIGH_NS = 400;
    localparam int CAL_RUN_NS  = 6400;
    localparam int CAL_LOW_CYC  = (CAL_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAL_HIGH_CYC = (CAL_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAL_RUN_CYC  = CAL_RUN_NS / CLK_NS;
    localparam int SYNC_STAGES  = 3;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic ext_n;
        logic dual_edge;
        logic low_power;
        logic cal;
        logic pd_i;
        logic pd_q;
        logic test_pat;
        logic demux;
        logic range;
    } pins_type;

    localparam logic [8:0] PINS_RESET = 9'h100;

    typedef enum logic [3:0] {
        CAL_WAIT_LOW = 4'h1,
        CAL_ARMED    = 4'h2,
        CAL_HIGH     = 4'h4,
        CAL_RUN      = 4'h8
    } cal_state_type;

endpackage

//--- tb/host_pins_model.sv
// Host-side model that drives the converter control pins
`timescale 1ns/1ns
module host_pins_model (
    input  wire logic             clk,  // Sampling clock
    input  adc_ctrl_pkg::pins_type want, // Levels the bench asks for
    output adc_ctrl_pkg::pins_type pins  // Levels on the control pins
);
    // ----------------------------------------
    // Pin driver
    // ----------------------------------------
    // Levels move just after an edge; the 10 MHz clock keeps power save legal
    initial pins = adc_ctrl_pkg::PINS_RESET;
    always @(posedge clk) begin
        pins <= want;
    end
endmodule

//--- tb/adc_mode_ctrl_test.sv
// Self-checking bench for the converter mode-control block
`timescale 1ns/1ns
module adc_mode_ctrl_test;
    localparam int RUN = 10;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        ref_a;
    logic        ref_b;
    logic        cal_run;
    wire  [22:0] got;
    logic [15:0] ctrl_m = 16'h0000;
    logic [15:0] ri_m = 16'h0080;
    logic [15:0] rq_m = 16'h0080;
    logic [7:0]  s;
    int          n_errors = 0;
    int          check_count = 0;
    int          n;
    adc_ctrl_pkg::pins_type want = adc_ctrl_pkg::PINS_RESET;
    adc_ctrl_pkg::pins_type pins;

    always #50 mclk = ~mclk;

    host_pins_model i_host (.clk(mclk), .want(want), .pins(pins));

    // Short calibration counts keep the run brief
    adc_mode_ctrl #(.CAL_LOW_CYC(2), .CAL_HIGH_CYC(2), .CAL_RUN_CYC(RUN)) i_dut (
        .MCLK(mclk), .RSTN(rstn), .EXTENDED_CONTROL_ENABLE_N(pins.ext_n),
        .DUAL_EDGE_SEL(pins.dual_edge), .LOW_RATE_POWER_SAVE(pins.low_power),
        .CALIB_REQ(pins.cal), .POWER_DOWN_I(pins.pd_i), .POWER_DOWN_Q(pins.pd_q),
        .TEST_PATTERN_SELECT(pins.test_pat), .DEMUX_RATIO_SELECT(pins.demux),
        .RANGE_SELECT(pins.range), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .REF_CLK_OUT_A(ref_a), .REF_CLK_OUT_B(ref_b),
        .DUAL_EDGE_MODE(got[22]), .LOW_POWER_MODE(got[21]), .OUT_DDR(got[20]),
        .DEMUX_1TO1(got[19]), .CH_I_OFF(got[18]), .CH_Q_OFF(got[17]),
        .TEST_PATTERN_ON(got[16]), .RANGE_I(got[15:8]), .RANGE_Q(got[7:0]),
        .CALIB_RUNNING(cal_run));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [22:0] expect_out(adc_ctrl_pkg::pins_type p, logic [15:0] c);
        logic       e;
        logic [7:0] r;
        e = ~p.ext_n;
        r = p.range ? adc_ctrl_pkg::RANGE_MID : adc_ctrl_pkg::RANGE_MIN;
        expect_out = {e ? c[7] : p.dual_edge, p.low_power, p.low_power ? p.demux : 1'b1,
                      p.demux, p.pd_i | (e & c[11]), p.pd_q | (e & c[10]),
                      e ? c[12] : p.test_pat, e ? ri_m[7:0] : r, e ? rq_m[7:0] : r};
    endfunction

    task automatic chk(input logic [22:0] g, input logic [22:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(23'(rdata), 23'(e));
    endtask

    // Writes in pin mode must be dropped, so the model only follows them in register mode
    task automatic rand_step(input logic ext_n);
        logic [15:0] v;
        logic [22:0] x;
        logic [15:0] st;
        v = 16'($urandom) & 16'h1c80;
        @(posedge mclk);
        want <= {ext_n, 8'($urandom) & 8'hdf};
        wr_reg(4'h0, v);
        if (!ext_n) begin
            ctrl_m = v;
            ri_m = 16'($urandom);
            rq_m = 16'($urandom);
            wr_reg(4'h3, ri_m);
            wr_reg(4'hb, rq_m);
        end
        cyc(7);
        x = expect_out(want, ctrl_m);
        st = {9'h000, 1'b0, x[16], x[17], x[18], x[19], x[21], x[22]};
        chk(got, x);
        rd_chk(4'h0, ctrl_m);
        rd_chk(4'h1, ext_n ? 16'h0000 : st);
    endtask

    task automatic count_run(input int k);
        n = 0;
        repeat (k) begin
            cyc(1);
            if (cal_run === 1'b1)
                n++;
        end
    endtask

    task automatic print_verdict;
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        void'($urandom(53918));
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        cyc(6);
        chk(got, expect_out(want, ctrl_m));
        chk(23'({ref_a, ref_b, cal_run}), 23'h0);
        repeat (16) rand_step(1'b1);
        @(posedge mclk);
        want <= 9'h000;
        cyc(6);
        rd_chk(4'he, 16'h0000);
        rd_chk(4'h3, 16'h0080);
        rd_chk(4'h5, 16'h0000);
        repeat (16) rand_step(1'b0);
        wr_reg(4'he, 16'h0002);
        cyc(6);
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            s[i] = ref_a;
            chk(23'(ref_b), 23'(ref_a));
        end
        chk(23'(s[5:0] ^ s[7:2]), 23'h3f);
        wr_reg(4'he, 16'h0000);
        cyc(3);
        chk(23'({ref_a, ref_b}), 23'h0);
        @(posedge mclk);
        want <= 9'h000;
        wr_reg(4'h0, 16'h0000);
        cyc(6);
        @(posedge mclk);
        want.cal <= 1'b1;
        count_run(40);
        chk(23'(n), 23'(RUN));
        count_run(20);
        chk(23'(n), 23'h0);
        @(posedge mclk);
        want.cal <= 1'b0;
        cyc(6);
        wr_reg(4'h0, 16'h8000);
        count_run(40);
        chk(23'(n), 23'(RUN));
        wr_reg(4'h0, 16'h1000);
        @(posedge mclk);
        want.ext_n <= 1'b1;
        cyc(8);
        @(posedge mclk);
        want.ext_n <= 1'b0;
        cyc(8);
        rd_chk(4'h0, 16'h0000);
        rd_chk(4'hb, 16'h0080);
        // Request bit high for one cycle only: too short, must not calibrate
        @(posedge mclk);
        wr <= 1'b1;
        addr <= 4'h0;
        wdata <= 16'h8000;
        @(posedge mclk);
        wdata <= 16'h0000;
        @(posedge mclk);
        wr <= 1'b0;
        count_run(20);
        chk(23'(n), 23'h0);
        print_verdict();
    end

    // Whole run needs under 2000 cycles
    initial begin
        #500000;
        n_errors++;
        print_verdict();
    end
endmodule
